// ==== pkg/srb_pkg.sv ====
// Package for the sensor result register bank: offsets, bit positions, codes.
// Assumes a byte-wide register access port driven by a serial front end on clk_in.
package srb_pkg;
    // Register word offsets (byte addresses of the low byte)
    localparam logic [7:0]  SRB_OFS_COMMAND   = 8'h22;
    localparam logic [7:0]  SRB_OFS_TEMP      = 8'h2E;
    localparam logic [7:0]  SRB_OFS_PRESS     = 8'h30;
    localparam logic [7:0]  SRB_OFS_SNAP      = 8'h32;
    localparam logic [7:0]  SRB_OFS_EVENT     = 8'h36;
    // Command codes
    localparam logic [15:0] SRB_CMD_SLEEP     = 16'h6C32;
    localparam logic [15:0] SRB_CMD_RESET     = 16'hB169;
    // Event status bit positions
    localparam int          SRB_BIT_IDLE      = 0;
    localparam int          SRB_BIT_PRESS_UP  = 3;
    localparam int          SRB_BIT_TEMP_UP   = 4;
    localparam int          SRB_BIT_BSUP      = 7;
    localparam int          SRB_BIT_BCHK      = 8;
    localparam int          SRB_BIT_SAT       = 10;
    localparam int          SRB_BIT_CRCERR    = 11;
    localparam int          SRB_BIT_PRESS_OV  = 14;
    localparam int          SRB_BIT_TEMP_OV   = 15;
    // Event-type bits, cleared by writing 1
    localparam logic [15:0] SRB_EVENT_MASK    = 16'hC998;
    // Reset values
    localparam logic [15:0] SRB_RST_WORD      = 16'h0000;
    // Configuration memory reload: word count and index of the last word read
    localparam logic [3:0]  SRB_RELOAD_WORDS  = 4'h8;
    localparam logic [3:0]  SRB_RELOAD_LAST   = 4'h7;

    typedef enum logic [1:0] {
        SRB_ST_LOAD  = 2'b00,
        SRB_ST_CHECK = 2'b01,
        SRB_ST_RUN   = 2'b10,
        SRB_ST_SLEEP = 2'b11
    } srb_state_t;
endpackage

// ==== hw/srb_boot_seq.sv ====
// Power-up sequence: walks the configuration memory, reloads it, checks its CRC.
// Assumes the memory answers a read address in the same cycle.
`timescale 1ns/1ps
module srb_boot_seq (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // Start request (commanded reset; the power-up walk starts from reset)
    input  wire logic        start_in,
    // Configuration memory
    output logic [3:0]       nvm_addr_out,
    input  wire logic [7:0]  nvm_data_in,
    // Result
    output logic             busy_out,
    output logic             crc_ok_out
);
    import srb_pkg::*;

    logic [3:0] idx_r;
    logic [7:0] crc_r;
    logic       busy_r;
    logic       ok_r;
    logic [7:0] crc_nxt;
    logic       last_w;

    // CRC-8, poly 0x07, over all bytes; a correct image leaves zero behind
    always_comb begin
        crc_nxt = crc_r ^ nvm_data_in;
        for (int i = 0; i < 8; i++) begin
            crc_nxt = crc_nxt[7] ? ((crc_nxt << 1) ^ 8'h07) : (crc_nxt << 1);
        end
    end

    assign last_w       = (idx_r == SRB_RELOAD_LAST);
    assign nvm_addr_out = idx_r;
    assign busy_out     = busy_r;
    assign crc_ok_out   = ok_r;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            idx_r  <= 4'h0;
            crc_r  <= 8'h00;
            busy_r <= 1'b1;
            ok_r   <= 1'b0;
        end else if (start_in) begin
            idx_r  <= 4'h0;
            crc_r  <= 8'h00;
            busy_r <= 1'b1;
            ok_r   <= 1'b0;
        end else if (busy_r) begin
            crc_r <= crc_nxt;
            idx_r <= idx_r + 4'h1;
            if (last_w) begin
                busy_r <= 1'b0;
                ok_r   <= (crc_nxt == 8'h00);
            end
        end
    end
endmodule

// ==== hw/srb_top.sv ====
// Sensor result register bank: command word, results, event and snapshot status.
// Assumes a serial front end on clk_in that presents byte reads and writes with
// an auto-incrementing byte address, and a measurement core on the same clock.
`timescale 1ns/1ps

module srb_top (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // Byte access from the serial front end
    input  wire logic        acc_start_in,
    input  wire logic [7:0]  acc_addr_in,
    input  wire logic        acc_rd_in,
    input  wire logic        acc_wr_in,
    input  wire logic [7:0]  acc_wdata_in,
    output logic [7:0]       acc_rdata_out,
    // Measurement core
    input  wire logic        temp_valid_in,
    input  wire logic [15:0] temp_value_in,
    input  wire logic        press_valid_in,
    input  wire logic [15:0] press_value_in,
    input  wire logic        sat_in,
    input  wire logic        bridge_supply_fault_in,
    input  wire logic        bridge_check_fault_in,
    input  wire logic        link_crc_fault_in,
    // Configuration memory
    output logic [3:0]       nvm_addr_out,
    input  wire logic [7:0]  nvm_data_in,
    // Device state
    output logic             sleep_out,
    output logic             measure_en_out,
    output logic             results_valid_out,
    output logic             crc_fail_out
);
    import srb_pkg::*;

    srb_state_t  state_r;
    srb_state_t  state_nxt;
    logic [7:0]  ptr_r;
    logic [7:0]  lo_hold_r;
    logic [15:0] temp_r;
    logic [15:0] press_r;
    logic [15:0] event_r;
    logic [15:0] event_nxt;
    logic [1:0]  snap_r;
    logic        temp_seen_r;
    logic        press_seen_r;
    logic        boot_start_r;
    logic [7:0]  rdata_r;
    logic        boot_busy;
    logic        boot_ok;

    // Address handling: byte pointer auto-increments across words
    wire  [7:0]  cur_addr     = acc_start_in ? acc_addr_in : ptr_r;
    wire  [7:0]  word_addr    = {cur_addr[7:1], 1'b0};
    wire         hi_byte      = cur_addr[0];
    wire         hit_cmd      = (word_addr == SRB_OFS_COMMAND);
    wire         hit_temp     = (word_addr == SRB_OFS_TEMP);
    wire         hit_press    = (word_addr == SRB_OFS_PRESS);
    wire         hit_snap     = (word_addr == SRB_OFS_SNAP);
    wire         hit_event    = (word_addr == SRB_OFS_EVENT);
    wire         acc_any      = acc_rd_in | acc_wr_in;
    wire         wr_hi        = acc_wr_in & hi_byte;
    wire  [15:0] wr_word      = {acc_wdata_in, lo_hold_r};
    // Word completes on its high byte; reading the high byte ends the word read
    wire         rd_temp_done = acc_rd_in & hi_byte & hit_temp;
    wire         rd_pres_done = acc_rd_in & hi_byte & hit_press;
    wire         run          = (state_r == SRB_ST_RUN);
    // Codes act on the high byte with the held low byte; any other value falls through
    wire         cmd_sleep    = wr_hi & hit_cmd & (wr_word == SRB_CMD_SLEEP);
    wire         cmd_reset    = wr_hi & hit_cmd & (wr_word == SRB_CMD_RESET);
    wire         ev_clear_wr  = wr_hi & hit_event;
    wire  [15:0] clr_mask     = ev_clear_wr ? (wr_word & SRB_EVENT_MASK) : 16'h0000;
    // Results only move while running after a good memory check
    wire         upd_temp     = run & boot_ok & temp_valid_in;
    wire         upd_press    = run & boot_ok & press_valid_in;
    wire  [15:0] snap_word;

    // Snapshot word: live mirror plus the two captured fresh bits
    wire  [10:0] snap_mirror_hi = event_r[15:5];
    wire  [2:0]  snap_mirror_lo = event_r[2:0];
    assign snap_word = {snap_mirror_hi, snap_r[1], snap_r[0], snap_mirror_lo};

    // Memory walk runs at power-up and again after every reset command
    srb_boot_seq u_boot (
        .clk_in       (clk_in),
        .resetn_in    (resetn_in),
        .start_in     (boot_start_r),
        .nvm_addr_out (nvm_addr_out),
        .nvm_data_in  (nvm_data_in),
        .busy_out     (boot_busy),
        .crc_ok_out   (boot_ok)
    );

    // Device state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SRB_ST_LOAD: begin
                // Start flag covers the cycle before the restarted walk shows busy
                if (!boot_busy && !boot_start_r) begin
                    state_nxt = SRB_ST_CHECK;
                end
            end
            SRB_ST_CHECK: begin
                state_nxt = SRB_ST_RUN;
            end
            SRB_ST_RUN: begin
                if (cmd_sleep) begin
                    state_nxt = SRB_ST_SLEEP;
                end
            end
            SRB_ST_SLEEP: begin
                state_nxt = SRB_ST_SLEEP;
            end
            default: begin
                state_nxt = SRB_ST_LOAD;
            end
        endcase
        // Reset command wins from any state; other codes fall through unchanged
        if (cmd_reset) begin
            state_nxt = SRB_ST_LOAD;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_r <= SRB_ST_LOAD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Boot restarts a cycle after the command, once the write has landed
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            boot_start_r <= 1'b0;
        end else begin
            boot_start_r <= cmd_reset;
        end
    end

    // Byte pointer; a start together with an access uses its address at once
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ptr_r <= 8'h00;
        end else if (acc_any) begin
            ptr_r <= cur_addr + 8'h01;
        end else if (acc_start_in) begin
            ptr_r <= acc_addr_in;
        end
    end

    // Low byte held until the high byte completes the word write
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lo_hold_r <= 8'h00;
        end else if (acc_wr_in && !hi_byte) begin
            lo_hold_r <= acc_wdata_in;
        end
    end

    // Event status next value: hardware sets win over clears
    always_comb begin
        event_nxt = event_r & ~clr_mask;
        if (rd_temp_done) begin
            event_nxt[SRB_BIT_TEMP_UP] = 1'b0;
        end
        if (rd_pres_done) begin
            event_nxt[SRB_BIT_PRESS_UP] = 1'b0;
        end
        if (upd_temp) begin
            event_nxt[SRB_BIT_TEMP_UP] = 1'b1;
            // Overrun judged on the old flag, before any clear this cycle
            if (event_r[SRB_BIT_TEMP_UP]) begin
                event_nxt[SRB_BIT_TEMP_OV] = 1'b1;
            end
        end
        if (upd_press) begin
            event_nxt[SRB_BIT_PRESS_UP] = 1'b1;
            if (event_r[SRB_BIT_PRESS_UP]) begin
                event_nxt[SRB_BIT_PRESS_OV] = 1'b1;
            end
        end

        // Fault pulses are kept as events until the host clears them
        if (bridge_supply_fault_in) begin
            event_nxt[SRB_BIT_BSUP] = 1'b1;
        end
        if (bridge_check_fault_in) begin
            event_nxt[SRB_BIT_BCHK] = 1'b1;
        end
        if (link_crc_fault_in) begin
            event_nxt[SRB_BIT_CRCERR] = 1'b1;
        end

        // Status-type bits follow their condition
        event_nxt[SRB_BIT_SAT]  = sat_in;
        event_nxt[SRB_BIT_IDLE] = run;
    end

    // Event status register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            event_r <= SRB_RST_WORD;
        end else begin
            event_r <= event_nxt;
        end
    end

    // Result words keep their values over a reset command
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            temp_r <= SRB_RST_WORD;
        end else if (upd_temp) begin
            temp_r <= temp_value_in;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            press_r <= SRB_RST_WORD;
        end else if (upd_press) begin
            press_r <= press_value_in;
        end
    end

    // Snapshot bits catch the old flag on the edge that clears it
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            snap_r <= 2'b00;
        end else begin
            if (rd_pres_done) begin
                snap_r[0] <= event_r[SRB_BIT_PRESS_UP];
            end
            if (rd_temp_done) begin
                snap_r[1] <= event_r[SRB_BIT_TEMP_UP];
            end
        end
    end

    // First-measurement flags; a reset command makes the results stale again
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            temp_seen_r  <= 1'b0;
            press_seen_r <= 1'b0;
        end else if (boot_start_r) begin
            temp_seen_r  <= 1'b0;
            press_seen_r <= 1'b0;
        end else begin
            if (upd_temp) begin
                temp_seen_r <= 1'b1;
            end
            if (upd_press) begin
                press_seen_r <= 1'b1;
            end
        end
    end

    // Read data: low byte at even address, high byte at odd; unmapped reads zero
    // Command word is write-only and reads as zero like any unmapped word
    wire  [15:0] rd_word = hit_temp  ? temp_r    :
                           hit_press ? press_r   :
                           hit_snap  ? snap_word :
                           hit_event ? event_r   : 16'h0000;
    wire  [7:0]  rd_byte = hi_byte ? rd_word[15:8] : rd_word[7:0];

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_r <= 8'h00;
        end else if (acc_rd_in) begin
            rdata_r <= rd_byte;
        end
    end

    // Registered read byte stands until the next read; state flags are levels
    assign acc_rdata_out     = rdata_r;
    assign sleep_out         = (state_r == SRB_ST_SLEEP);
    assign measure_en_out    = run;
    assign results_valid_out = temp_seen_r & press_seen_r;
    assign crc_fail_out      = run & ~boot_ok;
endmodule

// ==== verification/srb_props.sv ====
// Checker for srb_top: command effects, boot length, result validity, read port hold.
// Sees the top ports only; tracks the byte pointer and last low write byte itself.
`timescale 1ns/1ps
module srb_props
    import srb_pkg::*;
(
    input wire logic       clk_in,
    input wire logic       resetn_in,
    input wire logic       acc_start_in,
    input wire logic [7:0] acc_addr_in,
    input wire logic       acc_rd_in,
    input wire logic       acc_wr_in,
    input wire logic [7:0] acc_wdata_in,
    input wire logic [7:0] acc_rdata_out,
    input wire logic       sleep_out,
    input wire logic       measure_en_out,
    input wire logic       results_valid_out,
    input wire logic       crc_fail_out
);
    logic [7:0] ptr_r;
    logic [7:0] lo_r;
    logic [7:0] cur;
    logic       wr_cmd;
    logic       slp_cmd;
    logic       rst_cmd;
    assign cur = acc_start_in ? acc_addr_in : ptr_r;
    assign wr_cmd = acc_wr_in && cur == 8'h23;
    assign slp_cmd = wr_cmd && {acc_wdata_in, lo_r} == SRB_CMD_SLEEP;
    assign rst_cmd = wr_cmd && {acc_wdata_in, lo_r} == SRB_CMD_RESET;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ptr_r <= 8'h00;
            lo_r  <= 8'h00;
        end else if (acc_rd_in || acc_wr_in) begin
            ptr_r <= cur + 8'h01;
            lo_r  <= (acc_wr_in && !cur[0]) ? acc_wdata_in : lo_r;
        end else if (acc_start_in) begin
            ptr_r <= acc_addr_in;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    a_sleep_cmd: assert property (slp_cmd && measure_en_out |=> sleep_out && !measure_en_out)
        else $error("sleep command not obeyed");
    a_sleep_hold: assert property (sleep_out && !rst_cmd |=> sleep_out)
        else $error("sleep left without reset command");
    a_cmd_other: assert property (wr_cmd && !slp_cmd && !rst_cmd && measure_en_out |=> measure_en_out)
        else $error("unknown command changed state");
    a_reset_cmd: assert property (rst_cmd |=> (!sleep_out && !measure_en_out) ##1 !results_valid_out)
        else $error("reset command did not restart");
    a_boot_len: assert property ($fell(measure_en_out) && !sleep_out |-> ##[8:12] measure_en_out)
        else $error("boot sequence length wrong");
    a_crc_freeze: assert property (crc_fail_out |-> !results_valid_out)
        else $error("results valid with failed memory");
    a_valid_keep: assert property (results_valid_out && !rst_cmd && !$past(rst_cmd) |=> results_valid_out)
        else $error("results valid dropped");
    a_rdata_hold: assert property (!acc_rd_in |=> $stable(acc_rdata_out))
        else $error("read byte changed without read");
endmodule
bind srb_top srb_props u_srb_props (.clk_in(clk_in), .resetn_in(resetn_in), .acc_start_in(acc_start_in),
    .acc_addr_in(acc_addr_in), .acc_rd_in(acc_rd_in), .acc_wr_in(acc_wr_in), .acc_wdata_in(acc_wdata_in),
    .acc_rdata_out(acc_rdata_out), .sleep_out(sleep_out), .measure_en_out(measure_en_out),
    .results_valid_out(results_valid_out), .crc_fail_out(crc_fail_out));

// ==== verification/srb_host_model.sv ====
// Host model: issues single byte reads and writes on the access port.
// Assumes one calling process; each byte is held across its taken edge.
`timescale 1ns/1ps
module srb_host_model (
    input  wire logic  clk_in,
    output logic       acc_start_out,
    output logic [7:0] acc_addr_out,
    output logic       acc_rd_out,
    output logic       acc_wr_out,
    output logic [7:0] acc_wdata_out
);
    logic slow = 1'b0;
    initial begin
        acc_start_out = 1'b0;
        acc_addr_out = 8'h00;
        acc_rd_out = 1'b0;
        acc_wr_out = 1'b0;
        acc_wdata_out = 8'h00;
    end
    task automatic op(input logic s, input logic [7:0] a, input logic r, input logic w, input logic [7:0] d);
        @(posedge clk_in);
        acc_start_out <= s;
        acc_addr_out <= a;
        acc_rd_out <= r;
        acc_wr_out <= w;
        acc_wdata_out <= d;
        @(posedge clk_in);
        // Released lines show the inverse, never a stale copy
        acc_start_out <= 1'b0;
        acc_addr_out <= ~a;
        acc_rd_out <= 1'b0;
        acc_wr_out <= 1'b0;
        acc_wdata_out <= ~d;
        if (slow) repeat ($urandom_range(3, 1)) @(posedge clk_in);
    endtask
endmodule

// ==== verification/srb_top_bench.sv ====
// Bench for srb_top: host model on the access port, bench as sensor core and memory.
// Read bytes are checked by a monitor against a queue of expected bytes.
`timescale 1ns/1ps
module srb_top_bench;
    import srb_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        st, rd, wr, rd_seen = 1'b0;
    logic [7:0]  ad, wd, rdat, nvd;
    logic        tv = 1'b0, pv = 1'b0, sat = 1'b0, flt = 1'b0, bad = 1'b0;
    logic [15:0] tval = 16'h0000, pval = 16'h0000, et = 16'h0000, ep = 16'h0000;
    logic [3:0]  nva;
    logic        slp, men, rv, cf;
    logic [7:0]  exp_q[$];
    int          n_errors = 0;
    int          total_checks = 0;
    // One corrupt memory byte makes the boot check fail
    assign nvd = (bad && nva == 4'h3) ? 8'h5A : 8'h00;
    srb_top u_srb_top (
        .clk_in(clk), .resetn_in(rstn), .acc_start_in(st), .acc_addr_in(ad), .acc_rd_in(rd),
        .acc_wr_in(wr), .acc_wdata_in(wd), .acc_rdata_out(rdat), .temp_valid_in(tv),
        .temp_value_in(tval), .press_valid_in(pv), .press_value_in(pval), .sat_in(sat),
        .bridge_supply_fault_in(flt), .bridge_check_fault_in(flt), .link_crc_fault_in(flt),
        .nvm_addr_out(nva), .nvm_data_in(nvd), .sleep_out(slp), .measure_en_out(men),
        .results_valid_out(rv), .crc_fail_out(cf));
    srb_host_model u_srb_host_model (.clk_in(clk), .acc_start_out(st), .acc_addr_out(ad),
        .acc_rd_out(rd), .acc_wr_out(wr), .acc_wdata_out(wd));
    initial forever #4 clk = ~clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_run();
        int k;
        k = 0;
        while (men !== 1'b1 && k < 40) begin
            cyc(1);
            k++;
        end
        if (men !== 1'b1) begin
            n_errors++;
            end_sim();
        end
    endtask
    task automatic measure(input logic t, input logic p, input logic k);
        @(posedge clk);
        tv <= t;
        pv <= p;
        tval <= 16'($urandom);
        pval <= 16'($urandom);
        @(posedge clk);
        tv <= 1'b0;
        pv <= 1'b0;
        if (t && k) et = tval;
        if (p && k) ep = pval;
        cyc(2);
    endtask
    task automatic rd_words(input logic [7:0] a, input logic [15:0] w0, w1, w2, input int n);
        logic [15:0] w[3];
        w = '{w0, w1, w2};
        for (int i = 0; i < 2 * n; i++) begin
            exp_q.push_back(i % 2 ? w[i / 2][15:8] : w[i / 2][7:0]);
            u_srb_host_model.op(i == 0, a, 1'b1, 1'b0, 8'h00);
        end
    endtask
    task automatic wr_word(input logic [7:0] a, input logic [15:0] d);
        u_srb_host_model.op(1'b1, a, 1'b0, 1'b1, d[7:0]);
        u_srb_host_model.op(1'b0, a, 1'b0, 1'b1, d[15:8]);
    endtask
    always @(posedge clk) begin
        if (rd_seen) chk({8'h00, rdat}, {8'h00, exp_q.size() > 0 ? exp_q.pop_front() : ~rdat});
        rd_seen <= rd;
    end
    initial begin
        void'($urandom(32'h61223A3B));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        wait_run();
        chk({13'h0000, rv, cf, slp}, 16'h0000);
        rd_words(SRB_OFS_TEMP, 16'h0000, 16'h0000, 16'h0001, 3);
        measure(1'b1, 1'b1, 1'b1);
        chk({15'h0000, rv}, 16'h0001);
        rd_words(SRB_OFS_TEMP, et, ep, 16'h0019, 3);
        rd_words(SRB_OFS_TEMP, et, ep, 16'h0001, 3);
        measure(1'b0, 1'b1, 1'b1);
        measure(1'b1, 1'b1, 1'b1);
        u_srb_host_model.slow = 1'b1;
        rd_words(SRB_OFS_TEMP, et, ep, 16'h4019, 3);
        wr_word(SRB_OFS_SNAP, 16'hFFFF);
        wr_word(SRB_OFS_TEMP, 16'h1234);
        rd_words(SRB_OFS_TEMP, et, ep, 16'h4001, 3);
        wr_word(SRB_OFS_EVENT, 16'h4000);
        u_srb_host_model.slow = 1'b0;
        rd_words(SRB_OFS_SNAP, 16'h0001, et, ep, 1);
        flt <= 1'b1;
        sat <= 1'b1;
        @(posedge clk);
        flt <= 1'b0;
        cyc(2);
        rd_words(SRB_OFS_SNAP, 16'h0D81, et, ep, 1);
        sat <= 1'b0;
        wr_word(SRB_OFS_EVENT, 16'hFFFF);
        cyc(2);
        rd_words(SRB_OFS_SNAP, 16'h0001, et, ep, 1);
        wr_word(SRB_OFS_COMMAND, 16'h1234);
        cyc(2);
        chk({14'h0000, slp, men}, 16'h0001);
        wr_word(SRB_OFS_COMMAND, SRB_CMD_SLEEP);
        cyc(1);
        chk({14'h0000, slp, men}, 16'h0002);
        measure(1'b1, 1'b1, 1'b0);
        wr_word(SRB_OFS_COMMAND, SRB_CMD_RESET);
        cyc(1);
        chk({13'h0000, slp, men, rv}, 16'h0000);
        wait_run();
        rd_words(SRB_OFS_TEMP, et, ep, et, 2);
        bad <= 1'b1;
        wr_word(SRB_OFS_COMMAND, SRB_CMD_RESET);
        cyc(1);
        wait_run();
        chk({14'h0000, cf, rv}, 16'h0002);
        measure(1'b1, 1'b1, 1'b0);
        rd_words(SRB_OFS_TEMP, et, ep, et, 2);
        cyc(2);
        end_sim();
    end
endmodule
